// ### logic/sac_defs.svh
// constants for the successive approximation control block
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
`define SAC_WIDTH       12
`define SAC_SHORT_WIDTH 10
`define SAC_SHORT_SAVE  2
`define SAC_FULL_STEPS  13
`define SAC_SHORT_STEPS 11
`define SAC_MSB_IDX     11
`define SAC_SHORT_IDX   2
`define SAC_RESET_WORD  12'h7ff
`define SAC_IDLE_WORD   12'h000
`endif

// ### logic/sac_pkg.sv
// types shared by both ends of the conversion link
`include "sac_defs.svh"
package sac_pkg;
	typedef logic [`SAC_WIDTH-1:0] sac_word_t;
	typedef enum logic [1:0] {
		SAC_ST_CLEAR = 2'b00,
		SAC_ST_RUN   = 2'b01,
		SAC_ST_DONE  = 2'b10
	} sac_state_t;
	typedef enum logic [1:0] {
		SAC_HS_IDLE  = 2'b00,
		SAC_HS_START = 2'b01,
		SAC_HS_WAIT  = 2'b10
	} sac_host_state_t;
endpackage

// ### logic/sac_link_if.sv
// link between converter control and its external controller
`timescale 1ns/10ps
interface sac_link_if;
	import sac_pkg::*;
	logic      start_conversion;      // low holds clear, high runs
	logic      conversion_complete_n; // low when result valid
	sac_word_t result_bits;           // complemented binary result
	modport converter (
		input  start_conversion,
		output conversion_complete_n,
		output result_bits
	);
	modport controller (
		output start_conversion,
		input  conversion_complete_n,
		input  result_bits
	);
endinterface // sac_link_if

// ### logic/sac_converter.sv
// successive approximation register and completion logic of the converter
`timescale 1ns/10ps
`include "sac_defs.svh"
module sac_converter
	import sac_pkg::*;
#(
	parameter int WIDTH = `SAC_WIDTH
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// conversion clock enable, one-cycle pulse per conversion clock edge
	input  wire logic         conversion_clock,
	// comparator level from the analog side, asynchronous
	input  wire logic         comparator_output,
	// truncate to ten-bit accuracy
	input  wire logic         short_cycle,
	// link to the controller
	sac_link_if.converter     link
);
	////////////////////////////////////////////////////////////////////
	sac_state_t        state_reg, state_next;   // sequencer state
	logic [WIDTH-1:0]  sar_reg, sar_next;       // approximation register
	logic [WIDTH-1:0]  trial_reg, trial_next;   // one-hot bit under trial
	logic              done_n_reg, done_n_next; // completion, active low
	logic              cmp_meta_reg;            // synchroniser stage one
	logic              cmp_sync_reg;            // synchroniser stage two
	logic              start_meta_reg;          // start stage one
	logic              start_sync_reg;          // start stage two

	// stop index: short cycle ends after bit two is decided
	wire logic [WIDTH-1:0] last_trial = short_cycle ?
		WIDTH'(1) << (WIDTH - `SAC_SHORT_WIDTH) : WIDTH'(1);
	wire logic             at_last    = (trial_reg == last_trial);
	wire logic [WIDTH-1:0] cmp_fill   = cmp_sync_reg ? trial_reg : '0;
	wire logic [WIDTH-1:0] trial_bit  = (sar_reg & ~trial_reg) | cmp_fill;

	////////////////////////////////////////////////////////////////////
	// pins from outside pass two flip-flops; start may be tied to a pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmp_meta_reg   <= 1'b0;
			cmp_sync_reg   <= 1'b0;
			start_meta_reg <= 1'b0;
			start_sync_reg <= 1'b0;
		end else begin
			cmp_meta_reg   <= comparator_output;
			cmp_sync_reg   <= cmp_meta_reg;
			start_meta_reg <= link.start_conversion;
			start_sync_reg <= start_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// next-state logic; only conversion clock edges move anything
	always_comb begin
		state_next  = state_reg;
		sar_next    = sar_reg;
		trial_next  = trial_reg;
		done_n_next = done_n_reg;
		if (conversion_clock) begin
			if (!start_sync_reg && state_reg != SAC_ST_RUN) begin
				// synchronous clear: msb low, others high
				state_next  = SAC_ST_CLEAR;
				sar_next    = `SAC_RESET_WORD;
				trial_next  = WIDTH'(1) << (WIDTH - 1);
				done_n_next = 1'b1;
			end else begin
				unique case (state_reg)
					SAC_ST_CLEAR: begin
						// start high: first trial decides msb
						state_next = SAC_ST_RUN;
						sar_next   = trial_bit;
						trial_next = trial_reg >> 1;
						sar_next   = sar_next & ~(trial_reg >> 1);
					end
					SAC_ST_RUN: begin
						// start is not looked at here
						if (trial_reg == '0) begin
							// every bit down to the stop index decided: one more enable reports done
							state_next  = SAC_ST_DONE;
							done_n_next = 1'b0;
						end else if (at_last) begin
							// last trial takes the comparator, lower bits stay high
							sar_next   = trial_bit;
							trial_next = '0;
						end else begin
							sar_next   = trial_bit & ~(trial_reg >> 1);
							trial_next = trial_reg >> 1;
						end
					end
					SAC_ST_DONE: begin
						// result and completion stand still
						state_next = SAC_ST_DONE;
					end
					default: begin
						state_next = SAC_ST_CLEAR;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// state registers; completion starts high so no power-up lock-up
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg  <= SAC_ST_CLEAR;
			sar_reg    <= `SAC_RESET_WORD;
			trial_reg  <= WIDTH'(1) << (WIDTH - 1);
			done_n_reg <= 1'b1;
		end else begin
			state_reg  <= state_next;
			sar_reg    <= sar_next;
			trial_reg  <= trial_next;
			done_n_reg <= done_n_next;
		end
	end

	// register bits are the complemented binary result directly
	assign link.result_bits           = sar_reg;
	assign link.conversion_complete_n = done_n_reg;
endmodule // sac_converter

// ### logic/sac_controller.sv
// external controller that starts conversions and captures results
`timescale 1ns/10ps
`include "sac_defs.svh"
module sac_controller
	import sac_pkg::*;
(
	// clock and reset
	input  wire logic      clk,
	input  wire logic      rst,
	// conversion clock enable, same pulse the converter sees
	input  wire logic      conversion_clock,
	// user side
	input  wire logic      convert_req,   // pulse: request one conversion
	input  wire logic      continuous,    // level: tie completion to start
	input  wire logic      short_cycle,   // level: ten-bit short cycle
	output logic           sample_valid,  // pulse: captured word valid
	output sac_word_t      sample_word,   // captured complemented result
	output logic           busy,          // level: conversion pending
	// link to converter
	sac_link_if.controller link
);
	////////////////////////////////////////////////////////////////////
	sac_host_state_t state_reg, state_next; // handshake state
	logic            start_reg, start_next; // drives start_conversion
	logic            prev_cc_n_reg;         // completion last cycle
	logic            valid_reg;             // capture pulse
	sac_word_t       word_reg;              // captured word
	logic            pend_reg;              // request latched

	// short cycle ors bit two in, then ands with completion again, so completion is seen unchanged
	wire logic done_level = short_cycle ?
		(link.conversion_complete_n | link.result_bits[`SAC_SHORT_IDX]) &
		link.conversion_complete_n : link.conversion_complete_n;
	wire logic done_fall  = prev_cc_n_reg & ~done_level;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		start_next = start_reg;
		unique case (state_reg)
			SAC_HS_IDLE: begin
				// wait for completion low: a start pulse during a run would be lost
				if (pend_reg && conversion_clock && !link.conversion_complete_n) begin
					state_next = SAC_HS_START;
					start_next = 1'b0; // start low clears the register
				end
			end
			SAC_HS_START: begin
				// one conversion clock of low, then release
				if (conversion_clock) begin
					state_next = SAC_HS_WAIT;
					start_next = 1'b1;
				end
			end
			SAC_HS_WAIT: begin
				if (done_fall) begin
					state_next = SAC_HS_IDLE;
					start_next = continuous ? 1'b0 : 1'b1;
				end
			end
			default: begin
				state_next = SAC_HS_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg     <= SAC_HS_IDLE;
			start_reg     <= 1'b1;
			prev_cc_n_reg <= 1'b1;
			valid_reg     <= 1'b0;
			word_reg      <= `SAC_IDLE_WORD;
			pend_reg      <= 1'b0;
		end else begin
			state_reg     <= state_next;
			start_reg     <= start_next;
			prev_cc_n_reg <= done_level;
			valid_reg     <= done_fall && state_reg == SAC_HS_WAIT;
			if (done_fall && state_reg == SAC_HS_WAIT)
				word_reg <= link.result_bits;
			// request stays pending; continuous keeps it alive
			if (convert_req || continuous)
				pend_reg <= 1'b1;
			else if (state_reg == SAC_HS_START)
				pend_reg <= 1'b0;
		end
	end

	assign link.start_conversion = start_reg;
	assign sample_valid          = valid_reg;
	assign sample_word           = word_reg;
	assign busy                  = (state_reg != SAC_HS_IDLE);
endmodule // sac_controller

// ### testbench/sac_link_asserts.sv
// concurrent checks on the link between converter and controller
`timescale 1ns/10ps
`include "sac_defs.svh"
module sac_link_asserts
	import sac_pkg::*;
(
	// clock and reset
	input wire logic      clk,
	input wire logic      rst,
	// qualifiers that both ends see
	input wire logic      conversion_clock,
	input wire logic      short_cycle,
	// link signals
	input wire logic      start_conversion,
	input wire logic      conversion_complete_n,
	input wire sac_word_t result_bits
);
	logic [1:0] st_reg;   // start through the same two-stage delay as the converter
	logic [7:0] cnt_reg;  // enables spent on the running conversion
	logic [7:0] cnt_next; // next count
	wire        st_live = st_reg[1];
	// the count restarts on every clear, so a long idle cannot wrap into a match
	assign cnt_next = (!st_live || !conversion_complete_n) ? 8'h00 :
		(conversion_clock ? cnt_reg + 8'h01 : cnt_reg);
	////////////////////////////////////////////////////////////////////////////
	// helper state, reset to what the controller drives out of reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg  <= 2'b11;
			cnt_reg <= 8'h00;
		end else begin
			st_reg  <= {st_reg[0], start_conversion};
			cnt_reg <= cnt_next;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence clear_step_s;
		conversion_clock && !st_live && (!conversion_complete_n || result_bits == `SAC_RESET_WORD);
	endsequence
	sequence run_step_s;
		$past(conversion_complete_n) && conversion_complete_n && $changed(result_bits);
	endsequence
	idle_hold_a: assert property (!conversion_complete_n && st_live |=>
		$stable(result_bits) && !conversion_complete_n) else $error("result moved while done");
	clear_word_a: assert property (clear_step_s |=>
		result_bits == `SAC_RESET_WORD && conversion_complete_n) else $error("clear word wrong");
	cc_edge_a: assert property ($fell(conversion_complete_n) |-> $past(conversion_clock))
		else $error("completion fell without clock");
	word_edge_a: assert property ($changed(result_bits) |-> $past(conversion_clock))
		else $error("result moved without clock");
	step_shape_a: assert property (run_step_s |->
		$countones(result_bits ^ $past(result_bits)) <= 2) else $error("more than one step");
	conv_length_a: assert property ($fell(conversion_complete_n) |->
		$past(cnt_reg) == ($past(short_cycle) ? 8'h0a : 8'h0c)) else $error("conversion length");
	run_guard_a: assert property (conversion_complete_n && cnt_reg != 8'h00 |=>
		result_bits != `SAC_RESET_WORD || !conversion_complete_n) else $error("run restarted");
	rise_clear_a: assert property ($rose(conversion_complete_n) |->
		result_bits == `SAC_RESET_WORD) else $error("busy without clear");
endmodule // sac_link_asserts

// ### testbench/test_sar_adc_conversion_control.sv
// self-checking bench for both ends of the conversion link
`timescale 1ns/10ps
`include "sac_defs.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
	$display("Error %s expected %h seen %h", nm, exp, got); end end
module test_sar_adc_conversion_control
	import sac_pkg::*;
;
	logic      clk, rst, conversion_clock, comparator_output; // shared inputs
	logic      short_cycle, convert_req, continuous;          // user controls
	logic      sample_valid, busy;                            // user status
	sac_word_t sample_word, pattern;                          // capture, analog stand-in
	logic [2:0] div_reg;                                      // conversion clock divider
	int        fail_count, check_count;
	sac_link_if link ();
	sac_converter u_sac_converter (.clk(clk), .rst(rst), .conversion_clock(conversion_clock),
		.comparator_output(comparator_output), .short_cycle(short_cycle), .link(link));
	sac_controller u_sac_controller (.clk(clk), .rst(rst), .conversion_clock(conversion_clock),
		.convert_req(convert_req), .continuous(continuous), .short_cycle(short_cycle),
		.sample_valid(sample_valid), .sample_word(sample_word), .busy(busy), .link(link));
	sac_link_asserts u_sac_link_asserts (.clk(clk), .rst(rst), .conversion_clock(conversion_clock),
		.short_cycle(short_cycle), .start_conversion(link.start_conversion),
		.conversion_complete_n(link.conversion_complete_n), .result_bits(link.result_bits));
	////////////////////////////////////////////////////////////////////////////
	// bit under trial is the lowest zero, since lower bits stay high until tried
	function automatic int trial_idx(sac_word_t w);
		for (int i = 0; i < `SAC_WIDTH; i++) if (!w[i]) return i;
		return 0;
	endfunction
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// one enable in five clocks leaves room for the comparator sync latency
	always @(posedge clk) begin
		div_reg           <= (div_reg == 3'h4) ? 3'h0 : div_reg + 3'h1;
		conversion_clock  <= (div_reg == 3'h4);
		comparator_output <= pattern[trial_idx(link.result_bits)];
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// bounded wait for the captured word; a hang ends the run
	task automatic wait_valid(output sac_word_t got);
		for (int n = 0; n < 400; n++) begin
			@(posedge clk);
			#1;
			if (sample_valid === 1'b1) begin
				got = sample_word;
				return;
			end
		end
		fail_count++;
		print_verdict();
	endtask
	task automatic convert(sac_word_t pat, logic sh, sac_word_t mask);
		sac_word_t got;
		@(posedge clk);
		pattern     <= pat;
		short_cycle <= sh;
		convert_req <= 1'b1;
		@(posedge clk);
		convert_req <= 1'b0;
		wait_valid(got);
		`CHK("sample_word", pat & mask, got & mask)
		`CHK("result_bits", pat & mask, link.result_bits & mask)
		`CHK("complete_n", 1'b0, link.conversion_complete_n)
	endtask
	////////////////////////////////////////////////////////////////////////////
	// extremes and a mixed word, back to back
	task automatic full_runs();
		convert(12'h000, 1'b0, 12'hfff);
		convert(12'hfff, 1'b0, 12'hfff);
		convert(12'ha5c, 1'b0, 12'hfff);
	endtask
	task automatic hold_done();
		sac_word_t w;
		w = link.result_bits;
		repeat (60) @(posedge clk);
		#1;
		`CHK("held result", w, link.result_bits)
		`CHK("held complete_n", 1'b0, link.conversion_complete_n)
	endtask
	// the two lowest bits are never decided in short mode
	task automatic short_run();
		convert(12'h5a3, 1'b1, 12'hffc);
	endtask
	task automatic continuous_run();
		sac_word_t got;
		@(posedge clk);
		short_cycle <= 1'b0;
		pattern     <= 12'h3c6;
		continuous  <= 1'b1;
		wait_valid(got);
		wait_valid(got);
		`CHK("second continuous word", 12'h3c6, got)
		continuous <= 1'b0;
		for (int n = 0; n < 400 && busy !== 1'b0; n++) @(posedge clk);
		#1;
		`CHK("busy after stop", 1'b0, busy)
	endtask
	initial begin
		{rst, convert_req, continuous, short_cycle} = 4'h8;
		{conversion_clock, comparator_output, div_reg} = 5'h00;
		pattern     = 12'h000;
		fail_count  = 0;
		check_count = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		full_runs();
		hold_done();
		short_run();
		continuous_run();
		print_verdict();
	end
endmodule // test_sar_adc_conversion_control
